// File: hdl/ddrb_bank.sv
// dual channel converter code register bank: staging and output codes,
// page broadcast writes, software and pin load transfers
// assumes the spi front end delivers whole registers, one per cycle,
// and all inputs are synchronous to mclk
`timescale 1ns/1ps
`default_nettype none
`include "ddrb_consts.svh"

// Behaviour
// - fast page output write updates every selected channel output code
// - both selected: one page write updates both outputs, no strobe
// - fast select register, reset zero, steers later fast page writes
// - fast staging page write loads staging code of selected channels
// - fast software load write copies staging codes into outputs
// - software load acts like a low pulse on the strobe pin with no channel masked
// - staged codes move only on strobe or software load
// - fast staging registers at 0x33 and 0x35, sixteen bits, reset zero
// - fast output registers hold applied code, readable and writable
// - precise strobe mask register decides per channel strobe latching in precise mode
// - precise output codes 24 bits, data in 23:8, low byte reserved
// - precise page output write updates channels picked by precise select
// - precise staging page write loads staging of selected channels
// - precise software load write transfers staging codes to outputs
// - precise staging registers 24 bits, data 23:8, low byte reserved
// - internal reset held until both supply monitors report good
// - unmasked channel latches staging code on strobe pin assertion
// - masked channel output stays unchanged on strobe pin assertion
module ddrb_bank #(
  parameter int NUM_CH = 2,
  parameter int CODE_W = 16
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic avdd_ok,
  input wire logic dvdd_ok,
  input wire ddrb_pkg::ddrb_mode_e mode,
  input wire logic load_strobe_pin_n,
  input wire ddrb_pkg::ddrb_wreq_s wreq,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [23:0] rd_data,
  output logic rd_valid,
  output ddrb_pkg::ddrb_codes_s codes,
  output logic core_reset
);
  import ddrb_pkg::*;

  if (NUM_CH != 2 || CODE_W != 16) begin : g_bad_param
    $error("ddrb_bank serves two channels of sixteen bit codes only");
  end

  // ----------------------------------------------------------------
  // internal reset from the supply monitors
  // ----------------------------------------------------------------
  logic core_rst_q;
  logic supplies_ok;
  assign supplies_ok = avdd_ok & dvdd_ok;

  always_ff @(posedge mclk) begin
    if (reset) begin
      core_rst_q <= 1'b1;
    end else begin
      core_rst_q <= ~supplies_ok;
    end
  end
  assign core_reset = core_rst_q;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire wr = wreq.en & ~core_rst_q;
  wire [15:0] wr_fast = wreq.data[15:0];
  wire [15:0] wr_prec = wreq.data[23:`DDRB_PREC_LSB];
  wire wr_fast_mask = wr && wreq.addr == `DDRB_A_FAST_MASK;
  wire wr_prec_mask = wr && wreq.addr == `DDRB_A_PREC_MASK;
  wire wr_fast_sel = wr && wreq.addr == `DDRB_A_FAST_SEL;
  wire wr_prec_sel = wr && wreq.addr == `DDRB_A_PREC_SEL;
  wire wr_fast_pout = wr && wreq.addr == `DDRB_A_FAST_PAGE_OUT;
  wire wr_prec_pout = wr && wreq.addr == `DDRB_A_PREC_PAGE_OUT;
  wire wr_fast_pstg = wr && wreq.addr == `DDRB_A_FAST_PAGE_STG;
  wire wr_prec_pstg = wr && wreq.addr == `DDRB_A_PREC_PAGE_STG;
  wire wr_fast_swl = wr && wreq.addr == `DDRB_A_FAST_SW_LOAD;
  wire wr_prec_swl = wr && wreq.addr == `DDRB_A_PREC_SW_LOAD;
  wire [1:0] wr_fast_out;
  wire [1:0] wr_prec_out;
  wire [1:0] wr_fast_stg;
  wire [1:0] wr_prec_stg;
  assign wr_fast_out[0] = wr && wreq.addr == `DDRB_A_FAST_CH0_OUT;
  assign wr_fast_out[1] = wr && wreq.addr == `DDRB_A_FAST_CH1_OUT;
  assign wr_prec_out[0] = wr && wreq.addr == `DDRB_A_PREC_CH0_OUT;
  assign wr_prec_out[1] = wr && wreq.addr == `DDRB_A_PREC_CH1_OUT;
  assign wr_fast_stg[0] = wr && wreq.addr == `DDRB_A_FAST_CH0_STG;
  assign wr_fast_stg[1] = wr && wreq.addr == `DDRB_A_FAST_CH1_STG;
  assign wr_prec_stg[0] = wr && wreq.addr == `DDRB_A_PREC_CH0_STG;
  assign wr_prec_stg[1] = wr && wreq.addr == `DDRB_A_PREC_CH1_STG;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [1:0] fast_sel_q;
  logic [1:0] prec_sel_q;
  logic [1:0] fast_mask_q;
  logic [1:0] prec_mask_q;
  logic [15:0] fast_page_out_q;
  logic [15:0] prec_page_out_q;
  logic [15:0] fast_page_stg_q;
  logic [15:0] prec_page_stg_q;
  logic strobe_q;

  always_ff @(posedge mclk) begin
    if (core_rst_q) begin
      fast_sel_q <= `DDRB_BITS_RST;
      prec_sel_q <= `DDRB_BITS_RST;
      fast_mask_q <= `DDRB_BITS_RST;
      prec_mask_q <= `DDRB_BITS_RST;
      fast_page_out_q <= `DDRB_CODE_RST;
      prec_page_out_q <= `DDRB_CODE_RST;
      fast_page_stg_q <= `DDRB_CODE_RST;
      prec_page_stg_q <= `DDRB_CODE_RST;
      strobe_q <= `DDRB_STROBE_IDLE;
    end else begin
      if (wr_fast_sel) fast_sel_q <= wreq.data[1:0];
      if (wr_prec_sel) prec_sel_q <= wreq.data[1:0];
      if (wr_fast_mask) fast_mask_q <= wreq.data[1:0];
      if (wr_prec_mask) prec_mask_q <= wreq.data[1:0];
      if (wr_fast_pout) fast_page_out_q <= wr_fast;
      if (wr_prec_pout) prec_page_out_q <= wr_prec;
      if (wr_fast_pstg) fast_page_stg_q <= wr_fast;
      if (wr_prec_pstg) prec_page_stg_q <= wr_prec;
      strobe_q <= load_strobe_pin_n;
    end
  end

  // ----------------------------------------------------------------
  // load triggers
  // ----------------------------------------------------------------
  // falling edge on the pin; a held-low pin loads only once
  wire strobe_fall = strobe_q & ~load_strobe_pin_n & ~core_rst_q;
  wire sw_load = wr_fast_swl | wr_prec_swl;
  wire [1:0] strobe_mask = (mode == DDRB_PRECISE) ? prec_mask_q : fast_mask_q;
  // software load is the unmasked equivalent of a strobe pulse
  wire [1:0] load_ch = {2{sw_load}} | ({2{strobe_fall}} & ~strobe_mask);

  // ----------------------------------------------------------------
  // per channel staging and output codes
  // ----------------------------------------------------------------
  // both views share one 16 bit code per channel; the precise view
  // places it in 23:8 with a reserved low byte
  logic [1:0][15:0] stg_q;
  logic [1:0][15:0] stg_d;
  logic [1:0][15:0] out_q;
  logic [1:0][15:0] out_d;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire page_out = (wr_fast_pout & fast_sel_q[c]) |
      (wr_prec_pout & prec_sel_q[c]);
    wire page_stg = (wr_fast_pstg & fast_sel_q[c]) |
      (wr_prec_pstg & prec_sel_q[c]);

    // a direct register write in the same cycle overrides a load
    assign out_d[c] = wr_fast_out[c] ? wr_fast :
      wr_prec_out[c] ? wr_prec :
      (page_out && wr_fast_pout) ? wr_fast :
      page_out ? wr_prec :
      load_ch[c] ? stg_q[c] : out_q[c];

    assign stg_d[c] = wr_fast_stg[c] ? wr_fast :
      wr_prec_stg[c] ? wr_prec :
      (page_stg && wr_fast_pstg) ? wr_fast :
      page_stg ? wr_prec : stg_q[c];

    always_ff @(posedge mclk) begin
      if (core_rst_q) begin
        out_q[c] <= `DDRB_CODE_RST;
        stg_q[c] <= `DDRB_CODE_RST;
      end else begin
        out_q[c] <= out_d[c];
        stg_q[c] <= stg_d[c];
      end
    end
  end

  assign codes.ch0 = out_q[0];
  assign codes.ch1 = out_q[1];

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [23:0] rd_mux;
  always_comb begin
    rd_mux = 24'h000000;
    case (rd_addr)
      `DDRB_A_FAST_MASK: rd_mux = {22'h000000, fast_mask_q};
      `DDRB_A_FAST_CH0_OUT: rd_mux = {8'h00, out_q[0]};
      `DDRB_A_FAST_CH1_OUT: rd_mux = {8'h00, out_q[1]};
      `DDRB_A_FAST_PAGE_OUT: rd_mux = {8'h00, fast_page_out_q};
      `DDRB_A_FAST_SEL: rd_mux = {22'h000000, fast_sel_q};
      `DDRB_A_FAST_PAGE_STG: rd_mux = {8'h00, fast_page_stg_q};
      `DDRB_A_FAST_CH0_STG: rd_mux = {8'h00, stg_q[0]};
      `DDRB_A_FAST_CH1_STG: rd_mux = {8'h00, stg_q[1]};
      `DDRB_A_PREC_MASK: rd_mux = {22'h000000, prec_mask_q};
      `DDRB_A_PREC_CH0_OUT: rd_mux = {out_q[0], 8'h00};
      `DDRB_A_PREC_CH1_OUT: rd_mux = {out_q[1], 8'h00};
      `DDRB_A_PREC_PAGE_OUT: rd_mux = {prec_page_out_q, 8'h00};
      `DDRB_A_PREC_SEL: rd_mux = {22'h000000, prec_sel_q};
      `DDRB_A_PREC_PAGE_STG: rd_mux = {prec_page_stg_q, 8'h00};
      `DDRB_A_PREC_CH0_STG: rd_mux = {stg_q[0], 8'h00};
      `DDRB_A_PREC_CH1_STG: rd_mux = {stg_q[1], 8'h00};
      default: rd_mux = 24'h000000;
    endcase
  end

  // software load registers and unmapped offsets read as zero
  always_ff @(posedge mclk) begin
    if (core_rst_q) begin
      rd_data <= 24'h000000;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= rd_en ? rd_mux : rd_data;
      rd_valid <= rd_en;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_fast_page_out;
    @(posedge mclk) disable iff (core_rst_q)
    (wr_fast_pout && fast_sel_q == 2'h3) |=>
      (out_q[0] == $past(wr_fast) && out_q[1] == $past(wr_fast));
  endproperty
  a_fast_page_out: assert property (p_fast_page_out)
    else $error("fast page write missed a selected channel");

  property p_prec_page_out;
    @(posedge mclk) disable iff (core_rst_q)
    (wr_prec_pout && prec_sel_q[1]) |=> out_q[1] == $past(wr_prec);
  endproperty
  a_prec_page_out: assert property (p_prec_page_out)
    else $error("precise page write missed channel 1");

  property p_no_sel;
    @(posedge mclk) disable iff (core_rst_q)
    (wr_fast_pout && fast_sel_q == 2'h0 && !strobe_fall) |=> $stable(out_q);
  endproperty
  a_no_sel: assert property (p_no_sel)
    else $error("page write with no channel selected changed a code");

  property p_page_stg;
    @(posedge mclk) disable iff (core_rst_q)
    (wr_fast_pstg && fast_sel_q[0]) |=> stg_q[0] == $past(wr_fast);
  endproperty
  a_page_stg: assert property (p_page_stg)
    else $error("fast staging page write missed channel 0");

  property p_prec_page_stg;
    @(posedge mclk) disable iff (core_rst_q)
    (wr_prec_pstg && !prec_sel_q[1] && !wr_fast_stg[1] &&
      !wr_prec_stg[1]) |=> $stable(stg_q[1]);
  endproperty
  a_prec_page_stg: assert property (p_prec_page_stg)
    else $error("precise staging page write hit an unselected channel");

  property p_sw_load;
    @(posedge mclk) disable iff (core_rst_q)
    wr_fast_swl ##1 1'b1 |-> out_q == $past(stg_q);
  endproperty
  a_sw_load: assert property (p_sw_load)
    else $error("software load did not copy staging codes");

  property p_prec_sw_load;
    @(posedge mclk) disable iff (core_rst_q)
    wr_prec_swl |=> out_q[0] == $past(stg_q[0]);
  endproperty
  a_prec_sw_load: assert property (p_prec_sw_load)
    else $error("precise software load did not copy channel 0");

  property p_strobe_unmasked;
    @(posedge mclk) disable iff (core_rst_q)
    (mode == DDRB_PRECISE && strobe_q && !load_strobe_pin_n &&
      !prec_mask_q[1] && !wr) |=> out_q[1] == $past(stg_q[1]);
  endproperty
  a_strobe_unmasked: assert property (p_strobe_unmasked)
    else $error("unmasked channel ignored the load strobe");

  property p_strobe_masked;
    @(posedge mclk) disable iff (core_rst_q)
    (mode == DDRB_PRECISE && strobe_q && !load_strobe_pin_n &&
      prec_mask_q[0] && !wr) |=> $stable(out_q[0]);
  endproperty
  a_strobe_masked: assert property (p_strobe_masked)
    else $error("masked channel changed on the load strobe");

  property p_only_triggers;
    @(posedge mclk) disable iff (core_rst_q)
    (!wr && !strobe_fall) |=> $stable(out_q);
  endproperty
  a_only_triggers: assert property (p_only_triggers)
    else $error("output code moved without a trigger");

  property p_prec_view;
    @(posedge mclk) disable iff (core_rst_q)
    (rd_en && rd_addr == `DDRB_A_PREC_CH0_OUT) |=>
      rd_data == {$past(out_q[0]), 8'h00};
  endproperty
  a_prec_view: assert property (p_prec_view)
    else $error("precise output view misplaced the code");

  // codes clear one edge after the internal reset rises, not with it
  property p_supply_reset;
    @(posedge mclk) disable iff (reset)
    !supplies_ok |=> core_rst_q ##1 out_q == '0;
  endproperty
  a_supply_reset: assert property (p_supply_reset)
    else $error("internal reset released with a supply out of range");

  property p_fast_strobe_unmasked;
    @(posedge mclk) disable iff (core_rst_q)
    (mode == DDRB_FAST && strobe_q && !load_strobe_pin_n &&
      !fast_mask_q[0] && !wr) |=> out_q[0] == $past(stg_q[0]);
  endproperty
  a_fast_strobe_unmasked: assert property (p_fast_strobe_unmasked)
    else $error("unmasked channel 0 ignored the fast mode strobe");

  property p_fast_strobe_masked;
    @(posedge mclk) disable iff (core_rst_q)
    (mode == DDRB_FAST && strobe_q && !load_strobe_pin_n &&
      fast_mask_q[1] && !wr) |=> $stable(out_q[1]);
  endproperty
  a_fast_strobe_masked: assert property (p_fast_strobe_masked)
    else $error("masked channel 1 moved on the fast mode strobe");

  property p_direct_out;
    @(posedge mclk) disable iff (core_rst_q)
    wr_prec_out[0] |=> out_q[0] == $past(wr_prec);
  endproperty
  a_direct_out: assert property (p_direct_out)
    else $error("precise output write did not land in channel 0");

  property p_direct_stg;
    @(posedge mclk) disable iff (core_rst_q)
    wr_fast_stg[1] |=> stg_q[1] == $past(wr_fast);
  endproperty
  a_direct_stg: assert property (p_direct_stg)
    else $error("fast staging write did not land in channel 1");

  property p_fast_view;
    @(posedge mclk) disable iff (core_rst_q)
    (rd_en && rd_addr == `DDRB_A_FAST_CH0_OUT) |=>
      rd_valid && rd_data == {8'h00, $past(out_q[0])};
  endproperty
  a_fast_view: assert property (p_fast_view)
    else $error("fast output view misplaced the code");

  property p_reset_held;
    @(posedge mclk)
    reset |=> core_rst_q;
  endproperty
  a_reset_held: assert property (p_reset_held)
    else $error("internal reset not raised by the reset input");

  property p_core_refuse;
    @(posedge mclk)
    core_rst_q |=> out_q == '0 && stg_q == '0 && !rd_valid;
  endproperty
  a_core_refuse: assert property (p_core_refuse)
    else $error("codes survived the internal reset");

  property p_release;
    @(posedge mclk)
    $fell(core_rst_q) |-> $past(supplies_ok) && !$past(reset);
  endproperty
  a_release: assert property (p_release)
    else $error("internal reset released too early");

endmodule
`default_nettype wire

// File: hdl/ddrb_consts.svh
// register map and reset values of the dual channel code register bank
// assumes whole-register writes delivered by an spi front end
`ifndef DDRB_CONSTS_SVH
`define DDRB_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DDRB_A_FAST_MASK 8'h28
`define DDRB_A_FAST_CH0_OUT 8'h29
`define DDRB_A_FAST_CH1_OUT 8'h2b
`define DDRB_A_FAST_PAGE_OUT 8'h2d
`define DDRB_A_FAST_SEL 8'h2f
`define DDRB_A_FAST_PAGE_STG 8'h30
`define DDRB_A_FAST_SW_LOAD 8'h32
`define DDRB_A_FAST_CH0_STG 8'h33
`define DDRB_A_FAST_CH1_STG 8'h35
`define DDRB_A_PREC_MASK 8'h37
`define DDRB_A_PREC_CH0_OUT 8'h38
`define DDRB_A_PREC_CH1_OUT 8'h3b
`define DDRB_A_PREC_PAGE_OUT 8'h3e
`define DDRB_A_PREC_SEL 8'h41
`define DDRB_A_PREC_PAGE_STG 8'h42
`define DDRB_A_PREC_SW_LOAD 8'h45
`define DDRB_A_PREC_CH0_STG 8'h46
`define DDRB_A_PREC_CH1_STG 8'h49

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DDRB_PREC_LSB 8
`define DDRB_CODE_RST 16'h0000
`define DDRB_BITS_RST 2'h0
`define DDRB_STROBE_IDLE 1'b1

`endif

// File: hdl/ddrb_pkg.sv
// types shared by the code register bank and its users
// assumes nothing beyond the constants header
package ddrb_pkg;
  typedef enum logic {
    DDRB_FAST = 1'b0,
    DDRB_PRECISE = 1'b1
  } ddrb_mode_e;

  // one whole-register write from the spi front end
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [23:0] data;
  } ddrb_wreq_s;

  typedef struct packed {
    logic [15:0] ch1;
    logic [15:0] ch0;
  } ddrb_codes_s;
endpackage

// File: tb/ddrb_host.sv
// host side model: whole-register writes, reads and the load strobe pin
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module ddrb_host (
  input wire logic mclk,
  output ddrb_pkg::ddrb_wreq_s wreq,
  output logic rd_en,
  output logic [7:0] rd_addr,
  output logic load_strobe_pin_n,
  input wire logic [23:0] rd_data,
  input wire logic rd_valid
);
  import ddrb_pkg::*;
  initial begin
    wreq = '{1'b0, 8'h00, 24'h000000};
    rd_en = 1'b0;
    rd_addr = 8'h00;
    load_strobe_pin_n = 1'b1;
  end
  // ----------------------------------------
  // bus cycles
  // ----------------------------------------
  // one whole register per request, select set first by caller
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(negedge mclk);
    wreq = '{1'b1, a, d};
    @(negedge mclk);
    // released lines show the inverse, never the stale value
    wreq = '{1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [23:0] d,
                    output logic ok);
    @(negedge mclk);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_en = 1'b0;
    rd_addr = ~a;
    ok = rd_valid;
    d = rd_data;
  endtask
  // low for one sample, back high before any later load
  task automatic strobe();
    @(negedge mclk);
    load_strobe_pin_n = 1'b0;
    @(negedge mclk);
    load_strobe_pin_n = 1'b1;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire

// File: tb/ddrb_bank_tb_top.sv
// self-checking bench for the code register bank
// assumes the host model drives all bus inputs on falling edges
`timescale 1ns/1ps
`default_nettype none
module ddrb_bank_tb_top;
  import ddrb_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic avdd_ok = 1'b1;
  logic dvdd_ok = 1'b1;
  ddrb_mode_e mode = DDRB_FAST;
  ddrb_wreq_s wreq;
  logic rd_en;
  logic [7:0] rd_addr;
  logic [23:0] rd_data;
  logic rd_valid;
  logic strobe_n;
  ddrb_codes_s codes;
  logic core_reset;
  int fails = 0;
  int cmp_count = 0;
  logic [7:0] rst_addr [12] = '{8'h28, 8'h2f, 8'h30, 8'h33, 8'h35, 8'h37,
                                8'h38, 8'h3b, 8'h41, 8'h42, 8'h46, 8'h49};
  always #20 mclk = ~mclk;
  ddrb_bank i_ddrb_bank (.mclk(mclk), .reset(reset), .avdd_ok(avdd_ok),
    .dvdd_ok(dvdd_ok), .mode(mode), .load_strobe_pin_n(strobe_n),
    .wreq(wreq), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .codes(codes), .core_reset(core_reset));
  ddrb_host i_ddrb_host (.mclk(mclk), .wreq(wreq), .rd_en(rd_en),
    .rd_addr(rd_addr), .load_strobe_pin_n(strobe_n), .rd_data(rd_data),
    .rd_valid(rd_valid));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [23:0] d);
    i_ddrb_host.wr(a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [23:0] exp);
    logic [23:0] d;
    logic ok;
    i_ddrb_host.rd(a, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk({8'h00, d}, {8'h00, exp});
  endtask
  task automatic summarize();
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk({31'h0, core_reset}, 32'h0);
    chk(codes, 32'h0);
    foreach (rst_addr[i])
      rdchk(rst_addr[i], 24'h0);
  endtask
  task automatic t_fast_page();
    w(8'h2f, 24'h0);
    w(8'h2d, 24'h1234);
    chk(codes, 32'h0);
    w(8'h2f, 24'h1);
    w(8'h2d, 24'h1111);
    chk(codes, 32'h0000_1111);
    w(8'h2f, 24'h2);
    w(8'h2d, 24'h2222);
    chk(codes, 32'h2222_1111);
    rdchk(8'h2f, 24'h2);
    w(8'h2f, 24'h3);
    w(8'h2d, 24'hbeef);
    chk(codes, 32'hbeef_beef);
    rdchk(8'h29, 24'hbeef);
    w(8'h2b, 24'h5a5a);
    chk(codes, 32'h5a5a_beef);
  endtask
  task automatic t_stage();
    w(8'h30, 24'hc0de);
    rdchk(8'h33, 24'hc0de);
    rdchk(8'h35, 24'hc0de);
    chk(codes, 32'h5a5a_beef);
    w(8'h35, 24'hfeed);
    w(8'h32, 24'h01);
    chk(codes, 32'hfeed_c0de);
  endtask
  task automatic t_strobe();
    @(negedge mclk);
    mode = DDRB_PRECISE;
    w(8'h46, 24'h123400);
    w(8'h49, 24'h5678ff);
    rdchk(8'h49, 24'h567800);
    w(8'h37, 24'h01);
    i_ddrb_host.strobe();
    chk(codes, 32'h5678_c0de);
    w(8'h37, 24'h00);
    i_ddrb_host.strobe();
    chk(codes, 32'h5678_1234);
    // new staging through software load must reach both outputs
    w(8'h46, 24'h0a0a00);
    w(8'h49, 24'h0b0b00);
    w(8'h45, 24'h00);
    chk(codes, 32'h0b0b_0a0a);
  endtask
  task automatic t_prec_page();
    w(8'h41, 24'h02);
    w(8'h3e, 24'h777700);
    chk(codes, 32'h7777_0a0a);
    rdchk(8'h3b, 24'h777700);
    w(8'h41, 24'h01);
    w(8'h42, 24'h999900);
    rdchk(8'h46, 24'h999900);
    rdchk(8'h49, 24'h0b0b00);
    chk(codes, 32'h7777_0a0a);
  endtask
  // fast mode strobe uses the fast mask; the precise mask must not apply
  task automatic t_fast_strobe();
    @(negedge mclk);
    mode = DDRB_FAST;
    w(8'h37, 24'h01);
    w(8'h28, 24'h02);
    rdchk(8'h28, 24'h2);
    i_ddrb_host.strobe();
    chk(codes, 32'h7777_9999);
    w(8'h38, 24'h4321ab);
    chk(codes, 32'h7777_4321);
    rdchk(8'h38, 24'h432100);
    rdchk(8'h29, 24'h4321);
  endtask
  task automatic t_supply();
    @(negedge mclk);
    avdd_ok = 1'b0;
    @(negedge mclk);
    chk({31'h0, core_reset}, 32'h1);
    avdd_ok = 1'b1;
    dvdd_ok = 1'b0;
    @(negedge mclk);
    chk({31'h0, core_reset}, 32'h1);
    chk(codes, 32'h0);
    dvdd_ok = 1'b1;
    @(negedge mclk);
    chk({31'h0, core_reset}, 32'h0);
  endtask
  // ----------------------------------------
  // main sequence and hang guard
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge mclk);
    reset = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset();
    t_fast_page();
    t_stage();
    t_strobe();
    t_prec_page();
    t_fast_strobe();
    t_supply();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
